// ---- core/pirs_host_end.sv ----
`timescale 1ns/10ps
module pirs_host_end
  import pirs_pkg::*;
#(
  parameter int unsigned RST_CYC = RST_MIN_CYC,
  parameter int unsigned MIN_CYC = IRQ_MIN_CYC,
  parameter int unsigned MAX_CYC = IRQ_MAX_CYC
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  pirs_sb_if.host          sb,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Parameter checks at elaboration
  // Widths may be shortened for test; the defaults meet the reset minimum
  if (MIN_CYC < 1 || MIN_CYC > MAX_CYC || MAX_CYC >= RST_CYC) begin : g_bad
    $error("Host timing parameters inconsistent");
  end

  logic        line_s1;    // Line sync stage 1
  logic        line_s2;    // Line sync stage 2
  logic        prs_s1;     // Presence sync stage 1
  logic        prs_s2;     // Presence sync stage 2
  logic [1:0]  own_d;      // Own drive, aligned with line_s2
  logic [31:0] low_cnt;    // Module low run length
  logic        low_run;    // Module low in progress
  logic        irq_seen;   // Sticky interrupt seen
  logic        bad_pulse;  // Sticky out-of-range low
  logic [31:0] irq_count;  // Interrupts counted
  logic [31:0] rcnt;       // Reset drive counter
  logic        aw_got;     // Address held
  logic        w_got;      // Data held
  logic [31:0] awaddr_q;   // Held address
  logic [31:0] wdata_q;    // Held data
  logic [3:0]  wstrb_q;    // Held strobes

  logic        aw_take;    // Address handshake
  logic        w_take;     // Data handshake
  logic        do_write;   // Both halves present
  logic [31:0] wr_addr;    // Effective address
  logic [31:0] wr_data;    // Effective data
  logic        wr_lane0;   // Low byte written
  logic        irq_end;    // Valid interrupt ended
  logic        bad_end;    // Odd low ended
  logic        start_rst;  // Reset request accepted
  logic        w1c_irq;    // Clear irq_seen
  logic        w1c_bad;    // Clear bad_pulse
  logic [31:0] rd_word;    // Read mux
  logic        rd_err;     // Unmapped read

  // Write and pulse decode
  always_comb
  begin
    aw_take   = s_axi_awvalid && s_axi_awready;
    w_take    = s_axi_wvalid && s_axi_wready;
    do_write  = (aw_got || aw_take) && (w_got || w_take);
    wr_addr   = aw_got ? awaddr_q : s_axi_awaddr;
    wr_data   = w_got ? wdata_q : s_axi_wdata;
    wr_lane0  = w_got ? wstrb_q[0] : s_axi_wstrb[0];
    start_rst = do_write && wr_lane0 && (wr_addr == REG_CTRL) &&
                wr_data[CTRL_RESET] && !sb.host_oe;
    w1c_irq   = do_write && wr_lane0 && (wr_addr == REG_STATUS) && wr_data[ST_IRQ_SEEN];
    w1c_bad   = do_write && wr_lane0 && (wr_addr == REG_STATUS) && wr_data[ST_BAD_PULSE];
    irq_end   = low_run && line_s2 && low_cnt >= MIN_CYC && low_cnt <= MAX_CYC;
    bad_end   = low_run && line_s2 && !(low_cnt >= MIN_CYC && low_cnt <= MAX_CYC);
  end

  // Synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_s1 <= 1'b1;
      line_s2 <= 1'b1;
      prs_s1  <= 1'b1;
      prs_s2  <= 1'b1;
      own_d   <= 2'h0;
    end
    else
    begin
      line_s1 <= sb.line;
      line_s2 <= line_s1;
      prs_s1  <= sb.prsnt_n;
      prs_s2  <= prs_s1;
      own_d   <= {own_d[0], sb.host_oe};
    end
  end

  // Reset pulse driver, open collector
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sb.host_o  <= 1'b0;
      sb.host_oe <= 1'b0;
      rcnt       <= 32'h0;
    end
    else if (start_rst)
    begin
      sb.host_oe <= 1'b1;
      rcnt       <= RST_CYC - 1;
    end
    else if (sb.host_oe)
    begin
      if (rcnt == 32'h0)
        sb.host_oe <= 1'b0;
      else
        rcnt <= rcnt - 32'h1;
    end
  end

  // Module low measurement and sticky status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_cnt   <= 32'h0;
      low_run   <= 1'b0;
      irq_seen  <= 1'b0;
      bad_pulse <= 1'b0;
      irq_count <= 32'h0;
    end
    else
    begin
      if (!line_s2 && !own_d[1])
      begin
        low_run <= 1'b1;
        if (low_cnt != 32'hFFFF_FFFF)
          low_cnt <= low_cnt + 32'h1;
      end
      else
      begin
        low_run <= 1'b0;
        low_cnt <= 32'h0;
      end
      // Set wins over write-one-to-clear
      if (irq_end)
        irq_seen <= 1'b1;
      else if (w1c_irq)
        irq_seen <= 1'b0;
      if (bad_end)
        bad_pulse <= 1'b1;
      else if (w1c_bad)
        bad_pulse <= 1'b0;
      if (irq_end)
        irq_count <= irq_count + 32'h1;
    end
  end

  // Write channel handshakes and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      awaddr_q      <= 32'h0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
    end
    else if (do_write)
    begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b1;
      s_axi_bresp   <= (wr_addr == REG_CTRL || wr_addr == REG_STATUS ||
                        wr_addr == REG_IRQ_COUNT) ? RESP_OKAY : RESP_SLVERR;
    end
    else
    begin
      if (aw_take)
      begin
        aw_got        <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_got        <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read mux
  always_comb
  begin
    rd_word = 32'h0;
    rd_err  = 1'b0;
    case (s_axi_araddr)
      REG_CTRL:      rd_word[CTRL_RESET] = sb.host_oe;
      REG_STATUS:
      begin
        rd_word[ST_IRQ_SEEN]  = irq_seen;
        rd_word[ST_RST_BUSY]  = sb.host_oe;
        rd_word[ST_LINE]      = line_s2;
        rd_word[ST_PRESENT]   = !prs_s2;
        rd_word[ST_BAD_PULSE] = bad_pulse;
      end
      REG_IRQ_COUNT: rd_word = irq_count;
      default:       rd_err = 1'b1;
    endcase
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : pirs_host_end

// ---- core/pirs_module_end.sv ----
`timescale 1ns/10ps
// Behaviour
// - Presence output low whenever module seated
// - Host low resets, module low interrupts
// - Both ends only pull low or release
// - Low length tells interrupt from reset
// - Interrupt low lasts 5 to 50 us
// - Host reset low lasts at least 25 ms
// - Interrupts are pulses, line then released
// - Host reads cause over serial bus
// - Fully functional within 2000 ms of start
// - Serial bus answers within 2000 ms
// - Data-not-ready clears, interrupt raised at start
// - Line pulled low within 200 ms
// - Flag set and interrupt within 200 ms
// - Flag read clears it, line released
// - Loss of signal flagged within 100 ms
// - Transmit fault flagged within 200 ms
// - Mask inhibits, unmask resumes within 100 ms
// - Low power within 100, back 300 ms
// - Write timing counts from stop strobe
module pirs_module_end
  import pirs_pkg::*;
#(
  parameter int unsigned NFLAG     = FLAG_COUNT,
  parameter int unsigned PULSE_CYC = IRQ_USE_CYC,
  parameter int unsigned GAP_CYC   = IRQ_GAP_CYC,
  parameter int unsigned RST_CYC   = RST_MIN_CYC,
  parameter int unsigned SET_CYC   = SETTLE_CYC
)(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  pirs_sb_if.dev                sb,
  input  wire logic [NFLAG-1:1] cond,
  input  wire logic             rd_clr,
  input  wire logic [NFLAG-1:0] rd_clr_sel,
  input  wire logic             mask_wr,
  input  wire logic [NFLAG-1:0] mask_data,
  input  wire logic             lp_wr,
  input  wire logic             lp_data,
  output logic      [NFLAG-1:0] flags,
  output logic                  data_not_ready,
  output logic                  serial_ready,
  output logic                  fully_functional,
  output logic                  low_power,
  output logic                  host_reset_seen
);

  // Parameter checks at elaboration
  if (NFLAG < FLAG_COUNT || PULSE_CYC < IRQ_MIN_CYC || PULSE_CYC > IRQ_MAX_CYC ||
      GAP_CYC < 1 || RST_CYC < 2 || SET_CYC < 1 || SET_CYC > INIT_MAX_CYC) begin : g_bad
    $error("Module timing parameters out of range");
  end

  pirs_dev_state_t  state;        // Start-up state
  logic             line_s1;      // Line sync stage 1
  logic             line_s2;      // Line sync stage 2
  logic [1:0]       own_d;        // Own drive, aligned with line_s2
  logic [31:0]      rst_cnt;      // Foreign low run length
  logic             rst_armed;    // Foreign low long enough
  logic [31:0]      init_cnt;     // Settle counter
  logic [NFLAG-1:1] cond_d;       // Condition history
  logic [NFLAG-1:0] mask;         // Interrupt masks
  logic             irq_req;      // Pulse wanted
  logic             gapping;      // Quiet time after a pulse
  logic [31:0]      pcnt;         // Pulse and gap counter
  logic             drv;          // Module pulls line

  logic             ext_low;      // Low not caused by us
  logic             init_done;    // Settle finished this cycle
  logic             launch;       // Pulse starts this cycle
  logic [NFLAG-1:0] set_vec;      // Flag set events
  logic [NFLAG-1:0] clr_vec;      // Flag clear-on-read
  logic             unmask_pend;  // Unmask finds a pending flag

  // Event decode
  always_comb
  begin
    ext_low     = !line_s2 && !own_d[1];
    init_done   = (state == DS_INIT) && (init_cnt == SET_CYC - 1);
    launch      = irq_req && !drv && !gapping && line_s2 &&
                  (state == DS_RUN);
    set_vec     = {cond & ~cond_d, init_done};
    clr_vec     = rd_clr ? rd_clr_sel : '0;
    unmask_pend = mask_wr && |(flags & mask & ~mask_data);
  end

  // Line synchroniser and own-drive alignment
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_s1 <= 1'b1;
      line_s2 <= 1'b1;
      own_d   <= 2'h0;
    end
    else
    begin
      line_s1 <= sb.line;
      line_s2 <= line_s1;
      own_d   <= {own_d[0], drv};
    end
  end

  // Foreign low length, tells reset from our own pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ext_low)
    begin
      rst_cnt   <= 32'h0;
      rst_armed <= 1'b0;
    end
    else
    begin
      // Saturate once the reset width is reached
      if (rst_cnt < RST_CYC)
        rst_cnt <= rst_cnt + 32'h1;
      rst_armed <= (rst_cnt >= RST_CYC - 1);
    end
  end

  // Start-up sequence and host reset handling
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state    <= DS_INIT;
      init_cnt <= 32'h0;
    end
    else
    begin
      case (state)
        DS_INIT:
        begin
          // Settle, then go live
          if (rst_armed)
            state <= DS_HOST_RST;
          else if (init_done)
            state <= DS_RUN;
          init_cnt <= init_cnt + 32'h1;
        end
        DS_RUN:
        begin
          if (rst_armed)
            state <= DS_HOST_RST;
        end
        DS_HOST_RST:
        begin
          // Restart on the rising edge ending the reset
          if (line_s2)
          begin
            state    <= DS_INIT;
            init_cnt <= 32'h0;
          end
        end
        default:
        begin
          state    <= DS_INIT;
          init_cnt <= 32'h0;
        end
      endcase
    end
  end

  // Latched flags, set wins over clear-on-read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags  <= '0;
      cond_d <= '0;
    end
    else
    begin
      cond_d <= cond;
      if (state == DS_HOST_RST)
        flags <= '0;
      else
        flags <= (flags & ~clr_vec) | set_vec;
    end
  end

  // Mask and low-power bits, act at the stop strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == DS_HOST_RST)
    begin
      mask      <= '0;
      low_power <= 1'b0;
    end
    else
    begin
      if (mask_wr)
        mask <= mask_data;
      if (lp_wr)
        low_power <= lp_data;
    end
  end

  // Interrupt request, dropped if masked or read first
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state == DS_HOST_RST)
      irq_req <= 1'b0;
    else if (|(set_vec & ~mask) || unmask_pend)
      irq_req <= 1'b1;
    else if (launch || !(|(flags & ~mask & ~clr_vec)))
      irq_req <= 1'b0;
  end

  // Pulse timer: fixed low width, then a quiet gap
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drv     <= 1'b0;
      gapping <= 1'b0;
      pcnt    <= 32'h0;
    end
    else if (launch)
    begin
      drv  <= 1'b1;
      pcnt <= PULSE_CYC - 1;
    end
    else if (drv)
    begin
      if (pcnt == 32'h0)
      begin
        drv     <= 1'b0;
        gapping <= 1'b1;
        pcnt    <= GAP_CYC - 1;
      end
      else
        pcnt <= pcnt - 32'h1;
    end
    else if (gapping)
    begin
      if (pcnt == 32'h0)
        gapping <= 1'b0;
      else
        pcnt <= pcnt - 32'h1;
    end
  end

  // Pin drive: open collector only, presence grounded
  always_ff @(posedge aclk)
  begin
    sb.prsnt_n <= 1'b0;
    sb.dev_o   <= 1'b0;
    sb.dev_oe  <= aresetn && (launch || (drv && pcnt != 32'h0));
  end

  // Status outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_not_ready   <= 1'b1;
      serial_ready     <= 1'b0;
      fully_functional <= 1'b0;
      host_reset_seen  <= 1'b0;
    end
    else
    begin
      data_not_ready   <= !(init_done || state == DS_RUN);
      serial_ready     <= init_done || state == DS_RUN;
      fully_functional <= (init_done || state == DS_RUN) && !low_power;
      host_reset_seen  <= (state == DS_HOST_RST) && line_s2;
    end
  end

endmodule : pirs_module_end

// ---- core/pirs_pkg.sv ----
package pirs_pkg;

  // Clock rate in MHz
  localparam int unsigned CLK_MHZ       = 250;

  // Interrupt pulse limits and the width actually used, microseconds
  localparam int unsigned T_IRQ_MIN_US  = 5;
  localparam int unsigned T_IRQ_MAX_US  = 50;
  localparam int unsigned T_IRQ_USE_US  = 10;
  // Reset pulse least width, milliseconds
  localparam int unsigned T_RST_MIN_MS  = 25;
  // Start-up settle time used by the module, microseconds
  localparam int unsigned T_SETTLE_US   = 1000;
  // Start-up upper limit, milliseconds
  localparam int unsigned T_INIT_MAX_MS = 2000;

  // Derived cycle counts
  localparam int unsigned IRQ_MIN_CYC   = T_IRQ_MIN_US * CLK_MHZ;
  localparam int unsigned IRQ_MAX_CYC   = T_IRQ_MAX_US * CLK_MHZ;
  localparam int unsigned IRQ_USE_CYC   = T_IRQ_USE_US * CLK_MHZ;
  localparam int unsigned IRQ_GAP_CYC   = T_IRQ_USE_US * CLK_MHZ;
  localparam int unsigned RST_MIN_CYC   = T_RST_MIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned SETTLE_CYC    = T_SETTLE_US * CLK_MHZ;
  localparam int unsigned INIT_MAX_CYC  = T_INIT_MAX_MS * 1000 * CLK_MHZ;

  // Flag bit positions
  localparam int unsigned FLAG_COUNT    = 4;
  localparam int unsigned FLG_DATA_RDY  = 0;
  localparam int unsigned FLG_RX_LOS    = 1;
  localparam int unsigned FLG_TX_FAULT  = 2;
  localparam int unsigned FLG_OTHER     = 3;

  // Host register offsets
  localparam logic [31:0] REG_CTRL      = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS    = 32'h0000_0004;
  localparam logic [31:0] REG_IRQ_COUNT = 32'h0000_0008;
  // Host register fields
  localparam int unsigned CTRL_RESET    = 0;
  localparam int unsigned ST_IRQ_SEEN   = 0;
  localparam int unsigned ST_RST_BUSY   = 1;
  localparam int unsigned ST_LINE       = 2;
  localparam int unsigned ST_PRESENT    = 3;
  localparam int unsigned ST_BAD_PULSE  = 4;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Module start-up states
  typedef enum logic [1:0] {DS_INIT, DS_RUN, DS_HOST_RST} pirs_dev_state_t;

endpackage : pirs_pkg

// ---- core/pirs_sb_if.sv ----
`timescale 1ns/10ps
// Sideband link between module and host board
interface pirs_sb_if;
  logic prsnt_n;  // Module present, low when seated
  logic dev_o;    // Module line output value
  logic dev_oe;   // Module pulls line
  logic host_o;   // Host line output value
  logic host_oe;  // Host pulls line
  logic line;     // Resolved shared line

  // Open collector with pull-up: any enabled low wins
  assign line = !((dev_oe && !dev_o) || (host_oe && !host_o));

  modport dev  (output prsnt_n, output dev_o, output dev_oe, input line);
  modport host (input prsnt_n, output host_o, output host_oe, input line);
endinterface : pirs_sb_if

// ---- tb/pirs_sb_props.sv ----
`timescale 1ns/10ps
// Watches the shared sideband wires between both ends
module pirs_sb_props
  import pirs_pkg::*;
#(
  parameter int unsigned PULSE_CYC = IRQ_USE_CYC,
  parameter int unsigned RST_CYC   = RST_MIN_CYC
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic prsnt_n,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic line
);
  logic [31:0] dev_cnt;   // Cycles the module has pulled
  logic [31:0] host_cnt;  // Cycles the host has pulled

  // Module low-time counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !dev_oe)
      dev_cnt <= 32'h0;
    else
      dev_cnt <= dev_cnt + 32'h1;
  end

  // Host low-time counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !host_oe)
      host_cnt <= 32'h0;
    else
      host_cnt <= host_cnt + 32'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_present;
    prsnt_n == 1'h0;
  endproperty
  a_present: assert property (p_present)
    else $error("presence line high while seated");
  property p_dev_oc;
    dev_oe |-> dev_o == 1'h0;
  endproperty
  a_dev_oc: assert property (p_dev_oc)
    else $error("module drives line high");
  property p_host_oc;
    host_oe |-> host_o == 1'h0;
  endproperty
  a_host_oc: assert property (p_host_oc)
    else $error("host drives line high");
  property p_irq_width;
    $fell(dev_oe) |-> dev_cnt >= IRQ_MIN_CYC && dev_cnt <= IRQ_MAX_CYC;
  endproperty
  a_irq_width: assert property (p_irq_width)
    else $error("interrupt pulse width out of range");
  property p_irq_pulse;
    $fell(dev_oe) |-> dev_cnt == PULSE_CYC;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt pulse not of set width");
  property p_irq_gap;
    $fell(dev_oe) |-> !dev_oe [*8];
  endproperty
  a_irq_gap: assert property (p_irq_gap)
    else $error("line not released after pulse");
  property p_rst_width;
    $fell(host_oe) |-> host_cnt == RST_CYC;
  endproperty
  a_rst_width: assert property (p_rst_width)
    else $error("reset pulse width wrong");
  property p_no_clash;
    $rose(dev_oe) |-> !host_oe && $past(line);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("interrupt launched on a low line");

  // Main scenarios
  c_irq: cover property ($fell(dev_oe));
  c_rst: cover property ($fell(host_oe));
  c_low: cover property (!line && !host_oe);
endmodule : pirs_sb_props

// ---- tb/pluggable_irq_reset_sideband_test.sv ----
`timescale 1ns/10ps
// Drives both ends, models flags and interrupt count
module pluggable_irq_reset_sideband_test
  import pirs_pkg::*;
;
  localparam int unsigned RST = 13000;           // Shortened reset width
  localparam int unsigned SET = 50;              // Shortened settle time
  localparam int unsigned WIRQ = IRQ_USE_CYC + 100;
  logic        aclk, aresetn, rd_clr, mask_wr, lp_wr, lp_data;
  logic [3:1]  cond;
  logic [3:0]  rd_clr_sel, mask_data, flags, exp_flags, sel, wstrb;
  logic        data_not_ready, serial_ready, fully_functional;
  logic        low_power, host_reset_seen;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rs;
  int          num_errors, num_checks, exp_cnt, rst_seen;

  pirs_sb_if sb ();
  pirs_module_end #(.GAP_CYC(20), .RST_CYC(RST), .SET_CYC(SET)) pirs_module_end_inst (
    .aclk(aclk), .aresetn(aresetn), .sb(sb), .cond(cond), .rd_clr(rd_clr),
    .rd_clr_sel(rd_clr_sel), .mask_wr(mask_wr), .mask_data(mask_data), .lp_wr(lp_wr),
    .lp_data(lp_data), .flags(flags), .data_not_ready(data_not_ready),
    .serial_ready(serial_ready), .fully_functional(fully_functional),
    .low_power(low_power), .host_reset_seen(host_reset_seen));
  pirs_host_end #(.RST_CYC(RST)) pirs_host_end_inst (
    .aclk(aclk), .aresetn(aresetn), .sb(sb), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  pirs_sb_props #(.RST_CYC(RST)) pirs_sb_props_inst (
    .aclk(aclk), .aresetn(aresetn), .prsnt_n(sb.prsnt_n), .dev_o(sb.dev_o),
    .dev_oe(sb.dev_oe), .host_o(sb.host_o), .host_oe(sb.host_oe), .line(sb.line));

  // Clock
  always #2 aclk = ~aclk;

  // Counts reset-end pulses from the module
  always @(posedge aclk)
  begin
    if (host_reset_seen === 1'h1)
      rst_seen++;
  end

  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One bus write, both halves offered together
  task axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask : axi_wr

  // One bus read
  task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : axi_rd

  // Clear-on-read strobe
  task clr(input logic [3:0] s);
    @(posedge aclk);
    rd_clr <= 1'h1;
    rd_clr_sel <= s;
    @(posedge aclk);
    rd_clr <= 1'h0;
    exp_flags = exp_flags & ~s;
    repeat (3) @(posedge aclk);
    chk("flags", {28'h0, flags}, {28'h0, exp_flags});
  endtask : clr

  // Condition rise, then interrupt count compare
  task fire(input int b, input int inc);
    @(posedge aclk);
    cond[b] <= 1'h1;
    repeat (WIRQ) @(posedge aclk);
    exp_flags[b] = 1'h1;
    exp_cnt += inc;
    chk("flags", {28'h0, flags}, {28'h0, exp_flags});
    axi_rd(REG_IRQ_COUNT, rd, rs);
    chk("irq_count", rd, exp_cnt);
    cond[b] <= 1'h0;
  endtask : fire

  // Mask or low-power strobe
  task ctl(input logic m, input logic [3:0] d);
    @(posedge aclk);
    mask_wr <= m;
    lp_wr <= !m;
    mask_data <= d;
    lp_data <= d[0];
    @(posedge aclk);
    mask_wr <= 1'h0;
    lp_wr <= 1'h0;
    repeat (3) @(posedge aclk);
  endtask : ctl

  // Counts and verdict
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    end_sim;
  end

  // Main sequence
  initial
  begin
    {aclk, aresetn, rd_clr, mask_wr, lp_wr, lp_data, cond, rd_clr_sel, mask_data} = '0;
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    {num_errors, num_checks, exp_cnt, rst_seen} = '0;
    exp_flags = 4'h0;
    void'($urandom(28));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("prsnt_n", {31'h0, sb.prsnt_n}, 32'h0);
    chk("not_ready", {31'h0, data_not_ready}, 32'h1);
    repeat (SET + WIRQ) @(posedge aclk);
    exp_flags = 4'h1;
    exp_cnt = 1;
    chk("flags", {28'h0, flags}, 32'h1);
    chk("not_ready", {31'h0, data_not_ready}, 32'h0);
    chk("serial", {31'h0, serial_ready}, 32'h1);
    chk("func", {31'h0, fully_functional}, 32'h1);
    axi_rd(REG_STATUS, rd, rs);
    chk("status", rd, 32'hD);
    axi_wr(REG_STATUS, 32'h1, rs);
    clr(4'h1);
    $display("test startup done");
    for (int i = 1; i < 4; i++)
    begin
      fire(i, 1);
      sel = 4'($urandom) | (4'h1 << i);
      clr(sel);
    end
    $display("test flags done");
    ctl(1'h1, 4'h2);
    fire(1, 0);
    ctl(1'h1, 4'h0);
    repeat (WIRQ) @(posedge aclk);
    exp_cnt++;
    axi_rd(REG_IRQ_COUNT, rd, rs);
    chk("irq_count", rd, exp_cnt);
    clr(4'h2);
    fire(1, 1);
    clr(4'h2);
    $display("test mask done");
    ctl(1'h0, 4'h1);
    chk("low_power", {31'h0, low_power}, 32'h1);
    chk("func", {31'h0, fully_functional}, 32'h0);
    ctl(1'h0, 4'h0);
    chk("func", {31'h0, fully_functional}, 32'h1);
    $display("test low power done");
    axi_wr(32'h10, 32'h1, rs);
    chk("wr_resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_rd(32'h10, rd, rs);
    chk("rd_resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    chk("rd_data", rd, 32'h0);
    $display("test unmapped done");
    wstrb <= 4'($urandom) & 4'hE;
    axi_wr(REG_CTRL, 32'h1, rs);
    axi_rd(REG_CTRL, rd, rs);
    chk("busy", rd, 32'h0);
    wstrb <= 4'hF;
    axi_wr(REG_CTRL, 32'h1, rs);
    chk("wr_resp", {30'h0, rs}, {30'h0, RESP_OKAY});
    axi_rd(REG_CTRL, rd, rs);
    chk("busy", rd, 32'h1);
    repeat (RST + SET + WIRQ) @(posedge aclk);
    exp_flags = 4'h1;
    exp_cnt++;
    chk("rst_seen", rst_seen, 1);
    chk("flags", {28'h0, flags}, 32'h1);
    axi_rd(REG_IRQ_COUNT, rd, rs);
    chk("irq_count", rd, exp_cnt);
    $display("test host reset done");
    end_sim;
  end
endmodule : pluggable_irq_reset_sideband_test
